/* core/adcd_pkg.sv */
// shared constants and types for the decimation/offset configuration block
package adcd_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RATIO_LOW = 8'h9A;
    localparam logic [7:0] IDX_RATIO_HIGH = 8'h9B;
    localparam logic [7:0] IDX_OFFSET_DAC = 8'hBF;
    localparam logic [7:0] IDX_CONV_CTRL = 8'hC0;
    localparam logic [7:0] IDX_CONV_STATUS = 8'hC1;

    // reset values
    localparam logic [7:0] RST_RATIO_LOW = 8'hFF;
    localparam logic [7:0] RST_RATIO_HIGH = 8'h07;
    localparam logic [7:0] RST_OFFSET_DAC = 8'h00;

    // field layout
    localparam int RATIO_HIGH_MSB = 2;
    localparam int DAC_SIGN_BIT = 7;
    localparam int DAC_MAG_MSB = 6;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CAL_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;

    // smallest ratio setting the filter accepts; lower values are raised to it
    localparam logic [10:0] RATIO_FLOOR = 11'h013;

    // timing: modulator clock from system clock, modulator periods per sample
    localparam int SYS_CLK_NS = 20;
    localparam int MOD_CLK_NS = 80;
    localparam int MOD_DIV_CYC = (MOD_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [7:0] MOD_DIV = 8'(MOD_DIV_CYC);
    localparam logic [7:0] MOD_PER_SAMPLE = 8'h80;

    // conversion modes written by software
    typedef enum logic [1:0]
    {
        MODE_IDLE = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_CONTINUOUS = 2'b10
    } adcd_mode_t;

    // conversion timer states
    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } adcd_state_t;

    // apb request carried as one bundle
    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } adcd_apb_req_t;

    // byte address of a register index
    function automatic logic [11:0] adcd_addr(input logic [7:0] idx);
        adcd_addr = {2'b00, idx, 2'b00};
    endfunction : adcd_addr

    // ratio setting with the floor applied
    function automatic logic [10:0] adcd_eff_ratio(input logic [10:0] setting);
        adcd_eff_ratio = (setting < RATIO_FLOOR) ? RATIO_FLOOR : setting;
    endfunction : adcd_eff_ratio

endpackage : adcd_pkg

/* core/adcd_conv_timer.sv */
// conversion timer: paces output words from the modulator clock
`timescale 1ns/1ps
module adcd_conv_timer
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control
    input wire adcd_pkg::adcd_mode_t i_mode,
    input wire logic [10:0] i_ratio,
    // status
    output logic o_busy,
    output logic o_word,
    output logic o_mod_tick
);
    import adcd_pkg::*;

    adcd_state_t state_reg;
    logic [7:0] div_reg;
    logic [7:0] phase_reg;
    logic [10:0] samp_reg;
    logic [10:0] ratio_reg;
    logic div_last;
    logic phase_last;
    logic samp_last;

    assign div_last = (div_reg == MOD_DIV - 8'h01);
    assign phase_last = (phase_reg == MOD_PER_SAMPLE - 8'h01);
    assign samp_last = (samp_reg == ratio_reg);

    // state and latched ratio; ratio is frozen per conversion so a rewrite
    // mid-conversion cannot stretch or cut the current word
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            state_reg <= ST_IDLE;
            ratio_reg <= RATIO_FLOOR;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    // right after a single word the mode register is still one
                    // cycle from dropping; o_word blocks a false second start
                    if (i_mode != MODE_IDLE && !o_word)
                    begin
                        state_reg <= ST_RUN;
                        ratio_reg <= i_ratio;
                    end
                end
                ST_RUN:
                begin
                    if (i_mode == MODE_IDLE)
                        state_reg <= ST_IDLE;
                    else if (div_last && phase_last && samp_last)
                    begin
                        ratio_reg <= i_ratio;
                        if (i_mode == MODE_SINGLE)
                            state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // modulator clock divider and sample counters
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || state_reg == ST_IDLE)
        begin
            div_reg <= 8'h00;
            phase_reg <= 8'h00;
            samp_reg <= 11'h000;
        end
        else
        begin
            div_reg <= div_last ? 8'h00 : div_reg + 8'h01;
            if (div_last)
            begin
                phase_reg <= phase_last ? 8'h00 : phase_reg + 8'h01;
                if (phase_last)
                    samp_reg <= samp_last ? 11'h000 : samp_reg + 11'h001;
            end
        end
    end

    // registered outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_busy <= 1'b0;
            o_word <= 1'b0;
            o_mod_tick <= 1'b0;
        end
        else
        begin
            o_busy <= (state_reg == ST_RUN) && (i_mode != MODE_IDLE);
            o_word <= (state_reg == ST_RUN) && (i_mode != MODE_IDLE)
                && div_last && phase_last && samp_last;
            o_mod_tick <= (state_reg == ST_RUN) && div_last;
        end
    end

endmodule : adcd_conv_timer

/* core/adcd_top.sv */
// decimation ratio and offset dac registers with apb access and pacing
//
// Notes on behaviour
// - ratio high register holds ratio bits 10:8 in bits 2:0; resets 0x07.
// - low register is ratio bits 7:0; word spans (ratio+1)*128 modulator periods.
// - software programs at least 19; settings below 19 act as 19; low resets 0xFF.
// - offset dac is sign-magnitude, bit 7 negative, bits 6:0 magnitude; resets 0.
`timescale 1ns/1ps
module adcd_top
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // apb slave
    input wire adcd_pkg::adcd_apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // calibration engine status
    input wire logic i_cal_busy,
    // configuration to the filter and dac
    output logic [10:0] o_ratio_eff,
    output logic o_dac_negative,
    output logic [6:0] o_dac_magnitude,
    // conversion pacing
    output logic o_conv_busy,
    output logic o_word_strobe,
    output logic o_mod_tick
);
    import adcd_pkg::*;

    logic [7:0] ratio_low_reg;
    logic [2:0] ratio_high_reg;
    logic [7:0] offset_dac_reg;
    adcd_mode_t mode_reg;
    logic refused_reg;
    logic [10:0] ratio_eff_next;
    logic access;
    logic wr_fire;
    logic hit_low;
    logic hit_high;
    logic hit_dac;
    logic hit_ctrl;
    logic hit_stat;
    logic mapped;
    logic conv_idle;
    logic dac_wr;
    logic [31:0] rd_mux;
    logic timer_busy;
    logic timer_word;
    logic timer_tick;

    // address decode
    assign hit_low = (i_apb.paddr == adcd_addr(IDX_RATIO_LOW));
    assign hit_high = (i_apb.paddr == adcd_addr(IDX_RATIO_HIGH));
    assign hit_dac = (i_apb.paddr == adcd_addr(IDX_OFFSET_DAC));
    assign hit_ctrl = (i_apb.paddr == adcd_addr(IDX_CONV_CTRL));
    assign hit_stat = (i_apb.paddr == adcd_addr(IDX_CONV_STATUS));
    assign mapped = hit_low | hit_high | hit_dac | hit_ctrl | hit_stat;

    // access phase, and the completing edge where pready is already high
    assign access = i_apb.psel && i_apb.penable;
    assign wr_fire = access && o_pready && i_apb.pwrite;

    // converter idle means neither converting nor calibrating
    assign conv_idle = !timer_busy && (mode_reg == MODE_IDLE) && !i_cal_busy;
    assign dac_wr = wr_fire && hit_dac;

    // combined ratio with the floor applied
    assign ratio_eff_next = adcd_eff_ratio({ratio_high_reg, ratio_low_reg});

    // read data selection; unused bits read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_low)
            rd_mux[7:0] = ratio_low_reg;
        else if (hit_high)
            rd_mux[RATIO_HIGH_MSB:0] = ratio_high_reg;
        else if (hit_dac)
            rd_mux[7:0] = offset_dac_reg;
        else if (hit_ctrl)
            rd_mux[1:0] = mode_reg;
        else if (hit_stat)
        begin
            rd_mux[STAT_BUSY_BIT] = timer_busy;
            rd_mux[STAT_CAL_BIT] = i_cal_busy;
            rd_mux[STAT_REFUSED_BIT] = refused_reg;
        end
    end

    // apb handshake: one wait state, read data latched with pready
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (access && !o_pready)
        begin
            o_pready <= 1'b1;
            o_prdata <= i_apb.pwrite ? 32'h0000_0000 : rd_mux;
            o_pslverr <= !mapped;
        end
        else
        begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
    end

    // decimation ratio registers
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            ratio_low_reg <= RST_RATIO_LOW;
            ratio_high_reg <= RST_RATIO_HIGH[RATIO_HIGH_MSB:0];
        end
        else if (wr_fire)
        begin
            if (hit_low)
                ratio_low_reg <= i_apb.pwdata[7:0];
            if (hit_high)
                ratio_high_reg <= i_apb.pwdata[RATIO_HIGH_MSB:0];
        end
    end

    // offset dac register; a write while busy would glitch the analog offset
    // in the middle of a word, so it is dropped
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            offset_dac_reg <= RST_OFFSET_DAC;
        else if (dac_wr && conv_idle)
            offset_dac_reg <= i_apb.pwdata[7:0];
    end

    // refused-write flag: set by hardware, cleared by writing one; set wins
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            refused_reg <= 1'b0;
        else if (dac_wr && !conv_idle)
            refused_reg <= 1'b1;
        else if (wr_fire && hit_stat && i_apb.pwdata[STAT_REFUSED_BIT])
            refused_reg <= 1'b0;
    end

    // conversion mode; single mode falls back to idle after its word,
    // but a software write in that same cycle wins
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            mode_reg <= MODE_IDLE;
        else if (wr_fire && hit_ctrl)
        begin
            unique case (i_apb.pwdata[1:0])
                2'b01: mode_reg <= MODE_SINGLE;
                2'b10: mode_reg <= MODE_CONTINUOUS;
                default: mode_reg <= MODE_IDLE;
            endcase
        end
        else if (timer_word && mode_reg == MODE_SINGLE)
            mode_reg <= MODE_IDLE;
    end

    // configuration outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_ratio_eff <= adcd_eff_ratio({RST_RATIO_HIGH[RATIO_HIGH_MSB:0], RST_RATIO_LOW});
            o_dac_negative <= RST_OFFSET_DAC[DAC_SIGN_BIT];
            o_dac_magnitude <= RST_OFFSET_DAC[DAC_MAG_MSB:0];
        end
        else
        begin
            o_ratio_eff <= ratio_eff_next;
            o_dac_negative <= offset_dac_reg[DAC_SIGN_BIT];
            o_dac_magnitude <= offset_dac_reg[DAC_MAG_MSB:0];
        end
    end

    // pacing outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_conv_busy <= 1'b0;
            o_word_strobe <= 1'b0;
            o_mod_tick <= 1'b0;
        end
        else
        begin
            o_conv_busy <= timer_busy;
            o_word_strobe <= timer_word;
            o_mod_tick <= timer_tick;
        end
    end

    // word pacing from the modulator clock
    adcd_conv_timer u_timer
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_mode(mode_reg),
        .i_ratio(ratio_eff_next),
        .o_busy(timer_busy),
        .o_word(timer_word),
        .o_mod_tick(timer_tick)
    );

    // helper: cycles between word strobes, and the ratio behind them
    logic [23:0] gap_cnt;
    logic [10:0] gap_ratio;
    logic gap_valid;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || !timer_busy)
        begin
            gap_cnt <= 24'h000000;
            gap_valid <= 1'b0;
            gap_ratio <= ratio_eff_next;
        end
        else if (timer_word)
        begin
            gap_cnt <= 24'h000001;
            gap_valid <= 1'b1;
            gap_ratio <= ratio_eff_next;
        end
        else
            gap_cnt <= gap_cnt + 24'h000001;
    end

    a_ratio_floor: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_ratio_eff >= RATIO_FLOOR)
        else $error("effective ratio below floor");

    a_ratio_combine: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ({ratio_high_reg, ratio_low_reg} >= RATIO_FLOOR)
        |=> (o_ratio_eff == $past({ratio_high_reg, ratio_low_reg})))
        else $error("effective ratio does not follow registers");

    a_high_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_fire && hit_high)
        |=> (ratio_high_reg == $past(i_apb.pwdata[RATIO_HIGH_MSB:0]))
        ##1 (o_ratio_eff[10:8] == ratio_high_reg || o_ratio_eff == RATIO_FLOOR))
        else $error("high ratio bits not stored");

    a_dac_split: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (dac_wr && conv_idle)
        |-> ##2 (o_dac_negative == $past(i_apb.pwdata[7], 2))
        && (o_dac_magnitude == $past(i_apb.pwdata[6:0], 2)))
        else $error("offset dac sign or magnitude wrong");

    a_dac_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (dac_wr && !conv_idle) |=> $stable(offset_dac_reg) && refused_reg)
        else $error("offset dac changed while busy");

    a_word_period: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (timer_word && gap_valid && gap_ratio == ratio_eff_next)
        |-> (gap_cnt == 24'((32'(gap_ratio) + 32'd1) * 32'd128 * 32'(MOD_DIV))))
        else $error("word period not ratio plus one times 128 modulator periods");

    a_pready_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_pready |=> !o_pready)
        else $error("pready held for two cycles");

    a_unmapped_err: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (access && !o_pready && !mapped) |=> (o_pready && o_pslverr))
        else $error("unmapped access without error");

endmodule : adcd_top

/* testbench/adcd_top_tb.sv */
// self-checking bench for the decimation ratio and offset dac registers
`timescale 1ns/1ps
module adcd_top_tb;
    import adcd_pkg::*;
    // stimulus and observed outputs
    logic i_clk_sys;
    logic i_rst_n;
    logic i_cal_busy;
    adcd_apb_req_t req;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [10:0] o_ratio_eff;
    logic o_dac_negative;
    logic [6:0] o_dac_magnitude;
    logic o_conv_busy;
    logic o_word_strobe;
    logic o_mod_tick;
    int n_mismatch;
    int checked;
    logic [31:0] rd;
    logic err;
    int gap;
    int ticks;
    logic [7:0] set_v [5] = '{8'h00, 8'h12, 8'h13, 8'h14, 8'hFF};
    logic [10:0] eff_v [5] = '{11'h013, 11'h013, 11'h013, 11'h014, 11'h0FF};
    logic [7:0] dac_v [2] = '{8'h85, 8'h7F};

    adcd_top DUT
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_apb(req),
        .o_prdata(o_prdata),
        .o_pready(o_pready),
        .o_pslverr(o_pslverr),
        .i_cal_busy(i_cal_busy),
        .o_ratio_eff(o_ratio_eff),
        .o_dac_negative(o_dac_negative),
        .o_dac_magnitude(o_dac_magnitude),
        .o_conv_busy(o_conv_busy),
        .o_word_strobe(o_word_strobe),
        .o_mod_tick(o_mod_tick)
    );

    // 50 MHz system clock
    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // compare and count; four-state compare so unknowns fail
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge i_clk_sys);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= {2'b00, idx, 2'b00};
        req.pwdata <= {24'h000000, wd};
        @(posedge i_clk_sys);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while (o_pready !== 1'b1 && n < 50);
        rd = o_prdata;
        err = o_pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, o_pready});
    endtask : apb

    // read one register and compare the whole 32-bit read word
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, idx, 8'h00);
        chk(what, exp, rd);
    endtask : rdchk

    // cycles until the next output word strobe, and modulator ticks seen, bounded
    task automatic wait_word(output int n, output int t);
        n = 0;
        t = 0;
        do
        begin
            @(posedge i_clk_sys);
            n++;
            if (o_mod_tick === 1'b1)
                t++;
        end
        while (o_word_strobe !== 1'b1 && n < 30000);
    endtask : wait_word

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // hang guard: a little over twice the expected run
    initial
    begin
        repeat (70000) @(posedge i_clk_sys);
        n_mismatch++;
        results();
    end

    // test sequence
    initial
    begin
        i_rst_n = 1'b0;
        i_cal_busy = 1'b0;
        req = '0;
        n_mismatch = 0;
        checked = 0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        chk("ratio_eff reset", 32'h7FF, {21'h0, o_ratio_eff});
        rdchk(IDX_RATIO_LOW, 32'hFF, "ratio_low reset");
        rdchk(IDX_RATIO_HIGH, 32'h07, "ratio_high reset");
        rdchk(IDX_OFFSET_DAC, 32'h00, "dac reset");
        // unused high bits drop, ratio bits land at 10:8
        apb(1'b1, IDX_RATIO_HIGH, 8'hFA);
        rdchk(IDX_RATIO_HIGH, 32'h02, "ratio_high unused");
        chk("ratio_eff high", 32'h2FF, {21'h0, o_ratio_eff});
        apb(1'b1, IDX_RATIO_HIGH, 8'h00);
        // settings around the floor; readback stays raw
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, IDX_RATIO_LOW, set_v[i]);
            rdchk(IDX_RATIO_LOW, {24'h0, set_v[i]}, "ratio_low raw");
            chk("ratio_eff floor", {21'h0, eff_v[i]}, {21'h0, o_ratio_eff});
        end
        // sign and magnitude split
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, IDX_OFFSET_DAC, dac_v[i]);
            rdchk(IDX_OFFSET_DAC, {24'h0, dac_v[i]}, "dac readback");
            chk("dac sign", {31'h0, dac_v[i][7]}, {31'h0, o_dac_negative});
            chk("dac mag", {25'h0, dac_v[i][6:0]}, {25'h0, o_dac_magnitude});
        end
        // unmapped address answers with an error
        apb(1'b0, 8'h10, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        // dac write during calibration is dropped and flagged
        i_cal_busy <= 1'b1;
        apb(1'b1, IDX_OFFSET_DAC, 8'h33);
        i_cal_busy <= 1'b0;
        rdchk(IDX_OFFSET_DAC, 32'h7F, "dac cal hold");
        apb(1'b0, IDX_CONV_STATUS, 8'h00);
        chk("refused flag", 32'h1, {31'h0, rd[STAT_REFUSED_BIT]});
        apb(1'b1, IDX_CONV_STATUS, 8'h04);
        apb(1'b0, IDX_CONV_STATUS, 8'h00);
        chk("refused clear", 32'h0, {31'h0, rd[STAT_REFUSED_BIT]});
        // setting 0 acts as 19: words 20*128 modulator periods of 4 cycles apart
        apb(1'b1, IDX_RATIO_LOW, 8'h00);
        apb(1'b1, IDX_CONV_CTRL, 8'h02);
        wait_word(gap, ticks);
        wait_word(gap, ticks);
        chk("word gap", 32'd10240, gap);
        chk("mod ticks", 32'd2560, ticks);
        chk("conv busy", 32'h1, {31'h0, o_conv_busy});
        apb(1'b1, IDX_OFFSET_DAC, 8'h11);
        rdchk(IDX_OFFSET_DAC, 32'h7F, "dac busy hold");
        // once stopped and idle, the write is accepted
        apb(1'b1, IDX_CONV_CTRL, 8'h00);
        for (int n = 0; n < 100 && o_conv_busy !== 1'b0; n++)
            @(posedge i_clk_sys);
        apb(1'b1, IDX_OFFSET_DAC, 8'h11);
        rdchk(IDX_OFFSET_DAC, 32'h11, "dac idle write");
        // single mode: one word of 20*128*4 cycles plus 3 pipeline cycles, then idle
        apb(1'b1, IDX_CONV_CTRL, 8'h01);
        wait_word(gap, ticks);
        chk("single gap", 32'd10243, gap);
        rdchk(IDX_CONV_CTRL, 32'h00, "single ends");
        chk("single busy", 32'h0, {31'h0, o_conv_busy});
        results();
    end
endmodule : adcd_top_tb
